// ==== logic/flash_guard.v ====
// Flash program and erase sequencer with layered write protection
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_defs.vh"
module flash_guard #(
  parameter PAGE_BITS = 4, // Number of page address bits
  parameter OFS_BITS = 9, // Byte offset bits in a 512-byte page
  parameter SECT_BITS = 3, // Page bits that select a sector
  parameter PROG_CYCLES = `PROG_CYCLES, // Byte program time
  parameter ERASE_CYCLES = `ERASE_CYCLES // Erase time
) (
  input wire sys_clk, // 125 MHz system clock
  input wire sys_rst, // Synchronous active-high reset
  input wire write_protect_option, // Option bit, 1 allows CPU writes
  input wire debug_port_access, // Access comes from the debugger
  input wire ctrl_wr, // Control register write strobe
  input wire sel_wr, // Page-select / sector-protect write strobe
  input wire [7:0] wr_data, // Data for ctrl or select writes
  input wire mem_wr, // Byte program request
  input wire [PAGE_BITS+OFS_BITS-1:0] mem_addr, // Byte address
  input wire [7:0] mem_data, // Byte to program
  output reg [5:0] status, // Controller status code
  output reg [6:0] page_select, // Page select register
  output reg [7:0] sector_protect, // Sector protect register
  output reg cpu_stall, // Holds the CPU idle
  output reg arr_we, // Array write strobe
  output reg [PAGE_BITS+OFS_BITS-1:0] arr_addr, // Array address
  output reg [7:0] arr_wdata, // Array write data
  output reg busy // Operation in progress
);
  localparam AW = PAGE_BITS + OFS_BITS; // Byte address width
  localparam DEPTH = 1 << AW; // Bytes in the array
  localparam S_LOCKED = 3'd0; // Locked
  localparam S_CMD1 = 3'd1; // 73H seen
  localparam S_CMD2 = 3'd2; // 8CH seen, waiting page again
  localparam S_UNLK = 3'd3; // Page active
  localparam S_PROT = 3'd4; // Next select write hits protect
  localparam S_PROG = 3'd5; // Programming a byte
  localparam S_PERS = 3'd6; // Page erase running
  localparam S_MERS = 3'd7; // Mass erase running

  // How the sequencer is meant to be driven
  // Every control write is a single strobe with its byte on wr_data.
  // Select writes share one strobe for page select and sector protect;
  // which register they reach depends on the command seen before.
  // Program requests only count while a page is open.
  //
  // Command path
  // The locked state listens for the first unlock byte only.
  // A select write while locked records the candidate page.
  // After the first byte, a second byte either continues the unlock
  // or opens the protect register for exactly one select write.
  // Anything else on the control strobe drops straight back to locked,
  // so a runaway program cannot wander into an erase by accident.
  //
  // Page redundancy
  // The page is written twice around the unlock bytes.
  // A mismatch relocks, which catches a corrupted page pointer.
  // The debugger skips the second write and opens the first page.
  //
  // Protection layers
  // The option bit gates all CPU program and erase work.
  // The sector bits gate CPU work per sector and can only be set.
  // The debugger sees neither layer and may clear sector bits.
  //
  // Erase and program timing
  // Erase walks one byte per cycle, then waits out the timer.
  // The timer must cover the walk, or the erase ends late.
  // A program write lands once, at the end of its timer.
  // Programming ANDs with the old byte, so bits only fall.
  //
  // Limitations
  // The erased flags clear on relock, and every erase relocks,
  // so CPU byte programming is never accepted in any session.
  // The debugger is not tied to a region and can always program.
  // Only one operation runs at a time; strobes during it are ignored.
  // The CPU stays stalled for the full operation time.
  //
  // Status
  // Status trails the state by one cycle since it is registered.
  // Busy and stall share the same decode, registered alongside.
  reg [7:0] mem [0:DEPTH-1]; // Flash array model
  reg [2:0] state; // Sequencer state
  reg [2:0] prog_ret; // State to resume after a program
  reg [6:0] first_page; // Page latched before the unlock
  reg [6:0] active_page; // Page opened by the unlock
  reg erased_page; // A page erase has completed
  reg erased_all; // A mass erase has completed
  reg [23:0] timer; // Operation countdown
  reg [OFS_BITS-1:0] wipe_ofs; // Page erase walk
  reg [AW-1:0] wipe_addr; // Mass erase walk
  reg dbg; // Operation began from the debugger
  wire [2:0] act_sector; // Sector of the active page
  wire [6:0] mem_page; // Page of the programmed address
  wire [2:0] mem_sector; // Sector of the programmed address
  wire cpu_ok; // CPU may modify flash at all
  wire in_region; // Target lies in the writable region
  wire prog_ok; // Byte program accepted
  wire [7:0] old_byte; // Current array content

  // Sector is the top page bits; with 4 page bits and 3 sector bits each sector spans two pages
  assign act_sector = active_page[PAGE_BITS-1 -: SECT_BITS];
  assign mem_page = {{(7-PAGE_BITS){1'b0}}, mem_addr[AW-1:OFS_BITS]};
  assign mem_sector = mem_addr[AW-1 -: SECT_BITS];
  assign cpu_ok = write_protect_option;
  assign old_byte = mem[mem_addr];
  // Debugger is not tied to the page; CPU is bound to erase region
  assign in_region = debug_port_access ? 1'b1 :
    (erased_all | (erased_page & mem_page == active_page));
  assign prog_ok = (debug_port_access | (cpu_ok &
    ~sector_protect[mem_sector])) & in_region;

  // Main sequencer: one command path, one operation at a time
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state <= S_LOCKED;
      prog_ret <= S_LOCKED;
      page_select <= `PAGE_RESET;
      sector_protect <= `PROT_RESET;
      first_page <= `PAGE_RESET;
      active_page <= `PAGE_RESET;
      erased_page <= 1'b0;
      erased_all <= 1'b0;
      timer <= 24'h000000;
      wipe_ofs <= {OFS_BITS{1'b0}};
      wipe_addr <= {AW{1'b0}};
      dbg <= 1'b0;
      arr_we <= 1'b0;
      arr_addr <= {AW{1'b0}};
      arr_wdata <= 8'h00;
    end
    else
    begin
      arr_we <= 1'b0;
      case (state)
        S_LOCKED:
        begin
          erased_page <= 1'b0;
          erased_all <= 1'b0;
          if (ctrl_wr && wr_data == `CMD_UNLOCK1)
            state <= S_CMD1;
          else if (sel_wr)
          begin
            page_select <= wr_data[6:0];
            first_page <= wr_data[6:0];
          end
        end
        S_CMD1:
        begin
          if (ctrl_wr)
          begin
            // 8CH continues unlock, 5EH opens protect access
            if (wr_data == `CMD_UNLOCK2)
              state <= debug_port_access ? S_UNLK : S_CMD2;
            else if (wr_data == `CMD_PROT_SEL)
              state <= S_PROT;
            else
              state <= S_LOCKED;
            active_page <= first_page; // Debugger skips second write
          end
          else if (sel_wr)
            state <= S_LOCKED;
        end
        S_CMD2:
        begin
          if (sel_wr)
          begin
            page_select <= wr_data[6:0];
            // Redundant page must match the first one
            if (wr_data[6:0] == first_page)
            begin
              active_page <= first_page;
              state <= S_UNLK;
            end
            else
              state <= S_LOCKED;
          end
          else if (ctrl_wr)
            state <= S_LOCKED;
        end
        S_PROT:
        begin
          if (sel_wr)
          begin
            // CPU may only add protection; debugger may clear it
            if (debug_port_access)
              sector_protect <= wr_data;
            else
              sector_protect <= sector_protect | wr_data;
            state <= S_LOCKED;
          end
          else if (ctrl_wr)
            state <= S_LOCKED;
        end
        S_UNLK:
        begin
          if (ctrl_wr)
          begin
            dbg <= debug_port_access;
            timer <= ERASE_CYCLES[23:0];
            wipe_ofs <= {OFS_BITS{1'b0}};
            wipe_addr <= {AW{1'b0}};
            if (wr_data == `CMD_PAGE_ERASE && (debug_port_access |
                (cpu_ok & ~sector_protect[act_sector])))
              state <= S_PERS;
            else if (wr_data == `CMD_MASS_ERASE && debug_port_access)
              state <= S_MERS;
            else
              state <= S_LOCKED;
          end
          else if (sel_wr && debug_port_access)
          begin
            page_select <= wr_data[6:0];
            active_page <= wr_data[6:0];
          end
          else if (mem_wr)
          begin
            // Rejected writes are dropped and the page stays open
            if (prog_ok)
            begin
              arr_addr <= mem_addr;
              arr_wdata <= old_byte & mem_data;
              timer <= PROG_CYCLES[23:0];
              prog_ret <= S_UNLK;
              state <= S_PROG;
            end
            // Else flash unchanged
          end
        end
        S_PROG:
        begin
          // Write lands at the end of the program time
          if (timer == 24'h000001)
          begin
            arr_we <= 1'b1;
            state <= prog_ret;
          end
          timer <= timer - 24'h000001;
        end
        S_PERS:
        begin
          // Walk the page one byte per cycle, then time out
          if (~&wipe_ofs)
            wipe_ofs <= wipe_ofs + {{(OFS_BITS-1){1'b0}}, 1'b1};
          arr_we <= ~&wipe_ofs;
          arr_addr <= {active_page[PAGE_BITS-1:0], wipe_ofs};
          arr_wdata <= `ERASED_BYTE;
          if (timer == 24'h000001 && &wipe_ofs)
          begin
            arr_we <= 1'b1;
            erased_page <= 1'b1;
            state <= S_LOCKED;
          end
          if (timer != 24'h000001)
            timer <= timer - 24'h000001;
        end
        default:
        begin
          // Mass erase walks the whole array
          if (~&wipe_addr)
            wipe_addr <= wipe_addr + {{(AW-1){1'b0}}, 1'b1};
          arr_we <= ~&wipe_addr;
          arr_addr <= wipe_addr;
          arr_wdata <= `ERASED_BYTE;
          if (timer == 24'h000001 && &wipe_addr)
          begin
            arr_we <= 1'b1;
            erased_all <= 1'b1;
            state <= S_LOCKED;
          end
          if (timer != 24'h000001)
            timer <= timer - 24'h000001;
        end
      endcase
    end
  end

  // Array storage; erased content comes from the erase walk
  always @(posedge sys_clk)
  begin
    if (arr_we)
      mem[arr_addr] <= arr_wdata;
  end

  // Status and stall decode, registered for clean outputs
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      status <= `ST_LOCKED;
      cpu_stall <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      // Stall covers programs and erases from any source
      cpu_stall <= (state == S_PROG) | (state == S_PERS) |
        (state == S_MERS);
      busy <= (state == S_PROG) | (state == S_PERS) |
        (state == S_MERS);
      case (state)
        S_CMD1: status <= `ST_CMD1;
        S_CMD2: status <= `ST_CMD2;
        S_UNLK: status <= `ST_UNLOCKED;
        S_PROT: status <= `ST_PROT_SEL;
        S_PROG: status <= `ST_PROGRAM;
        S_PERS: status <= `ST_PAGE_ERASE;
        S_MERS: status <= `ST_MASS_ERASE;
        default: status <= `ST_LOCKED;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/flash_guard_defs.vh ====
// Constants for the flash program and erase sequencer
`ifndef FLASH_GUARD_DEFS_VH
`define FLASH_GUARD_DEFS_VH
`define CMD_UNLOCK1 8'h73
`define CMD_UNLOCK2 8'h8c
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63
`define CMD_PROT_SEL 8'h5e
`define ERASED_BYTE 8'hff
`define PROT_RESET 8'h00
`define PAGE_RESET 7'h00
`define ST_LOCKED 6'h00
`define ST_CMD1 6'h01
`define ST_CMD2 6'h02
`define ST_UNLOCKED 6'h03
`define ST_PROT_SEL 6'h04
`define ST_PROGRAM 6'h08
`define ST_PAGE_ERASE 6'h10
`define ST_MASS_ERASE 6'h20
`define PROG_TIME_NS 40000
`define PROG_CYCLES ((`PROG_TIME_NS + 7) / 8)
`define ERASE_TIME_NS 10000000
`define ERASE_CYCLES ((`ERASE_TIME_NS + 7) / 8)
`endif

// ==== testbench/flash_array_model.sv ====
// Mirror model of the flash array behind the sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  input wire logic sys_clk, // System clock
  input wire logic arr_we, // Write strobe
  input wire logic [12:0] arr_addr, // Byte address
  input wire logic [7:0] arr_wdata // Byte value
);
  logic [7:0] mem [0:8191]; // Array contents
  // Start off erased-looking but not FFH, so a missed erase shows up
  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'h5a;
  end
  // Store each strobed byte as driven
  always @(posedge sys_clk)
  begin
    if (arr_we)
      mem[arr_addr] <= arr_wdata;
  end
endmodule
`default_nettype wire

// ==== testbench/flash_guard_sva.sv ====
// Assertions on the ports of the flash sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_guard_sva (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Sync reset
  input wire logic write_protect_option, // Option bit
  input wire logic debug_port_access, // Debugger access
  input wire logic ctrl_wr, // Control write
  input wire logic mem_wr, // Program request
  input wire logic [5:0] status, // Status code
  input wire logic [7:0] sector_protect, // Protect bits
  input wire logic cpu_stall, // CPU hold
  input wire logic arr_we, // Array write
  input wire logic [7:0] arr_wdata, // Array data
  input wire logic busy // Operation active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  reset_locked_a: assert property (disable iff (1'b0)
    sys_rst |=> status == 6'h00 && !busy && !cpu_stall)
    else $error("outputs not idle after reset");
  stall_busy_a: assert property (busy |-> cpu_stall)
    else $error("busy without cpu stall");
  protect_sticky_a: assert property (!debug_port_access |=>
    (sector_protect & $past(sector_protect)) == $past(sector_protect))
    else $error("protect bit cleared by cpu");
  erase_ff_a: assert property (arr_we && status[5:4] != 2'b00
    |-> arr_wdata == 8'hff) else $error("erase data not ff");
  cmd_order_a: assert property (status == 6'h02 &&
    $past(status) != 6'h02 |-> $past(status) == 6'h01)
    else $error("second step without first");
  unlock_src_a: assert property (status == 6'h03 &&
    $past(status) != 6'h03 |->
    $past(status) inside {6'h01, 6'h02, 6'h08})
    else $error("unlocked from wrong state");
  mass_debug_a: assert property (status == 6'h20 &&
    $past(status) != 6'h20 |-> $past(debug_port_access, 2))
    else $error("mass erase without debugger");
  wp_erase_a: assert property ($rose(status == 6'h10) |->
    $past(write_protect_option, 2) || $past(debug_port_access, 2))
    else $error("page erase under write protect");
  busy_cause_a: assert property ($rose(busy) |-> $past(ctrl_wr) ||
    $past(mem_wr) || $past(ctrl_wr, 2) || $past(mem_wr, 2))
    else $error("busy without request");
  write_in_op_a: assert property (arr_we |-> busy || $past(busy))
    else $error("array write outside operation");
  cover property (status == 6'h10);
  cover property (status == 6'h20);
  cover property (status == 6'h08);
  cover property (sector_protect != 8'h00);
endmodule
bind flash_guard flash_guard_sva chk_u (.sys_clk, .sys_rst,
  .write_protect_option, .debug_port_access, .ctrl_wr, .mem_wr,
  .status, .sector_protect, .cpu_stall, .arr_we, .arr_wdata, .busy);
`default_nettype wire

// ==== testbench/test_flash_guard.sv ====
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/10ps
`default_nettype none
module test_flash_guard;
  logic sys_clk = 1'b0; // Clock
  logic sys_rst = 1'b1; // Reset
  logic write_protect_option = 1'b1; // Option bit
  logic debug_port_access = 1'b0; // Debugger access
  logic ctrl_wr = 1'b0; // Control write
  logic sel_wr = 1'b0; // Select write
  logic [7:0] wr_data = 8'h00; // Register data
  logic mem_wr = 1'b0; // Program request
  logic [12:0] mem_addr = 13'h0000; // Program address
  logic [7:0] mem_data = 8'h00; // Program data
  logic [5:0] status; // Status code
  logic [7:0] sector_protect; // Protect bits
  logic cpu_stall; // CPU hold
  logic busy; // Operation active
  logic arr_we; // Array write
  logic [12:0] arr_addr; // Array address
  logic [7:0] arr_wdata; // Array data
  int fail_count = 0; // Mismatches
  int checks_done = 0; // Comparisons
  always #4 sys_clk = ~sys_clk;
  // Short counts keep erase runs brief
  flash_guard #(.PROG_CYCLES(4), .ERASE_CYCLES(600)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .write_protect_option(write_protect_option),
    .debug_port_access(debug_port_access), .ctrl_wr(ctrl_wr),
    .sel_wr(sel_wr), .wr_data(wr_data), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_data(mem_data), .status(status),
    .page_select(), .sector_protect(sector_protect),
    .cpu_stall(cpu_stall), .arr_we(arr_we), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .busy(busy));
  flash_array_model arr_u (.sys_clk(sys_clk), .arr_we(arr_we),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One-cycle control (c=1) or select (c=0) write, then settle
  task automatic wr(input logic c, input logic [7:0] v);
    @(posedge sys_clk);
    ctrl_wr <= c;
    sel_wr <= !c;
    wr_data <= v;
    @(posedge sys_clk);
    ctrl_wr <= 1'b0;
    sel_wr <= 1'b0;
    tick(3);
  endtask
  // Full unlock; a new CPU page always takes a fresh sequence
  task automatic unlock(input logic [7:0] p);
    wr(1'b0, p);
    wr(1'b1, 8'h73);
    wr(1'b1, 8'h8c);
    wr(1'b0, p);
  endtask
  task automatic prog(input logic [12:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_data <= d;
    @(posedge sys_clk);
    mem_wr <= 1'b0;
    tick(12);
  endtask
  // Bounded wait for the end of an operation
  task automatic idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 40000)
    begin
      tick(1);
      n++;
    end
    if (n == 40000)
      fail_count++;
    tick(3);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    tick(6);
    sys_rst <= 1'b0;
    tick(2);
    chk({2'b00, status}, 8'h00);
    chk(sector_protect, 8'h00);
    prog(13'h0400, 8'h00);
    chk(arr_u.mem[13'h0400], 8'h5a);
    unlock(8'h02);
    chk({2'b00, status}, 8'h03);
    prog(13'h0401, 8'h00);
    chk(arr_u.mem[13'h0401], 8'h5a);
    wr(1'b1, 8'h95);
    chk({2'b00, status}, 8'h10);
    chk({7'h00, cpu_stall}, 8'h01);
    idle;
    chk({2'b00, status}, 8'h00);
    chk(arr_u.mem[13'h0400], 8'hff);
    chk(arr_u.mem[13'h05ff], 8'hff);
    chk(arr_u.mem[13'h0600], 8'h5a);
    wr(1'b1, 8'h73);
    wr(1'b1, 8'h5e);
    chk({2'b00, status}, 8'h04);
    wr(1'b0, 8'h02);
    chk(sector_protect, 8'h02);
    wr(1'b1, 8'h73);
    wr(1'b1, 8'h5e);
    wr(1'b0, 8'h00);
    chk(sector_protect, 8'h02);
    unlock(8'h03);
    wr(1'b1, 8'h95);
    idle;
    chk(arr_u.mem[13'h0600], 8'h5a);
    unlock(8'h04);
    wr(1'b1, 8'h12);
    chk({2'b00, status}, 8'h00);
    wr(1'b0, 8'h05);
    wr(1'b1, 8'h73);
    wr(1'b1, 8'h8c);
    wr(1'b0, 8'h06);
    chk({2'b00, status}, 8'h00);
    write_protect_option <= 1'b0;
    unlock(8'h04);
    wr(1'b1, 8'h95);
    idle;
    chk(arr_u.mem[13'h0800], 8'h5a);
    write_protect_option <= 1'b1;
    unlock(8'h04);
    wr(1'b1, 8'h63);
    idle;
    chk(arr_u.mem[13'h0800], 8'h5a);
    debug_port_access <= 1'b1;
    write_protect_option <= 1'b0;
    wr(1'b1, 8'h73);
    wr(1'b1, 8'h5e);
    wr(1'b0, 8'h00);
    chk(sector_protect, 8'h00);
    wr(1'b0, 8'h00);
    wr(1'b1, 8'h73);
    wr(1'b1, 8'h8c);
    wr(1'b1, 8'h63);
    chk({2'b00, status}, 8'h20);
    idle;
    chk({2'b00, status}, 8'h00);
    chk(arr_u.mem[13'h0600], 8'hff);
    chk(arr_u.mem[13'h1fff], 8'hff);
    wr(1'b0, 8'h03);
    wr(1'b1, 8'h73);
    wr(1'b1, 8'h8c);
    prog(13'h0600, 8'h3c);
    chk(arr_u.mem[13'h0600], 8'h3c);
    prog(13'h0600, 8'hf0);
    chk(arr_u.mem[13'h0600], 8'h30);
    chk({2'b00, status}, 8'h03);
    wr(1'b1, 8'h00);
    chk({2'b00, status}, 8'h00);
    conclude;
  end
  // Watchdog against a hung wait
  initial
  begin
    tick(90000);
    fail_count++;
    conclude;
  end
endmodule
`default_nettype wire
